/* File: hdl/qei_core.sv */
// Quadrature encoder interface with position counter, filters and timer mode.
// Assumes encoder pins are asynchronous; sleep and idle come from the core.
//
// The APB register port and the placing of the registers were left to the implementer.
module qei_core
  import qei_pkg::*;
#(
  parameter int DIV_W = 3
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        phase_a_input,
  input  wire logic        phase_b_input,
  input  wire logic        index_input,
  input  wire logic        cpu_sleep,
  input  wire logic        cpu_idle,
  output logic             count_direction_out,
  output logic             count_direction_oe_n,
  output logic             module_interrupt_flag
);
  logic [15:0] control_reg;
  logic [15:0] filter_reg;
  logic [15:0] position_count_reg;
  logic [15:0] maximum_count_reg;
  logic        count_error_flag_reg;
  logic        dir_reg;
  logic        irq_reg;
  enc_t        sync1_reg, sync2_reg, flt_reg, prev_reg;
  enc_t        hist0_reg, hist1_reg;
  logic [6:0]  div_cnt_reg;
  logic        flt_tick;
  enc_t        use_in;
  mode_t       mode;
  logic        run, x2, x4, idx_mode, max_mode, tmr_mode;
  logic        a_edge, b_edge, step, up, idx_evt;
  logic        wr, rd_ok;
  logic [15:0] pos_next;
  logic        wrap_evt, err_evt, period_evt;
  logic [16:0] max_p1;

  assign mode     = mode_t'(control_reg[CTL_MODE_LO +: 3]);
  assign x2       = (mode == MODE_X2IDX) || (mode == MODE_X2MAX);
  assign x4       = (mode == MODE_X4IDX) || (mode == MODE_X4MAX);
  assign idx_mode = (mode == MODE_X2IDX) || (mode == MODE_X4IDX);
  assign max_mode = (mode == MODE_X2MAX) || (mode == MODE_X4MAX);
  assign tmr_mode = (mode == MODE_TIMER);
  assign run = !cpu_sleep && !(cpu_idle && control_reg[CTL_IDLE]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end
    else
    begin
      sync1_reg <= {index_input, phase_b_input, phase_a_input};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_reg <= '0;
    else if (run)
      div_cnt_reg <= div_cnt_reg + 7'h01;
  end
  always_comb
  begin
    flt_tick = 1'b1;
    for (int i = 0; i < 7; i++)
      if (i < int'(filter_reg[FLT_DIV_LO +: DIV_W]) && !div_cnt_reg[i])
        flt_tick = 1'b0;
  end

  // three equal samples before output changes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      hist0_reg <= '0;
      hist1_reg <= '0;
      flt_reg   <= '0;
    end
    else if (run && flt_tick)
    begin
      hist0_reg <= sync2_reg;
      hist1_reg <= hist0_reg;
      for (int k = 0; k < FILTER_TAPS; k++)
        if (sync2_reg[k] == hist0_reg[k] && hist0_reg[k] == hist1_reg[k])
          flt_reg[k] <= sync2_reg[k];
    end
  end

  assign use_in = filter_reg[FLT_OUTEN] ? flt_reg : sync2_reg;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prev_reg <= '0;
    else if (run)
      prev_reg <= use_in;
  end

  assign a_edge  = use_in.phase_a ^ prev_reg.phase_a;
  assign b_edge  = use_in.phase_b ^ prev_reg.phase_b;
  assign idx_evt = use_in.index && !prev_reg.index;
  // step selection; timer clock is phase A rise
  assign step = run && ((x2 && a_edge) || (x4 && (a_edge || b_edge))
                || (tmr_mode && use_in.phase_a && !prev_reg.phase_a));
  // A leading B forward: A edge with A!=B, or B edge with A==B
  // timer direction from phase B pin or direction bit
  assign up = tmr_mode ? (control_reg[CTL_DIRSRC] ? use_in.phase_b : control_reg[CTL_DIR])
            : (a_edge ? (use_in.phase_a != use_in.phase_b)
                      : (use_in.phase_a == use_in.phase_b));
  assign max_p1 = {1'b0, maximum_count_reg} + 17'h00001;

  // Next position and events
  always_comb
  begin
    pos_next   = position_count_reg;
    wrap_evt   = 1'b0;
    err_evt    = 1'b0;
    period_evt = 1'b0;
    if (step)
    begin
      pos_next = up ? position_count_reg + 16'h0001 : position_count_reg - 16'h0001;
      if (max_mode || tmr_mode)
      begin
        if (up && position_count_reg == maximum_count_reg)
          pos_next = 16'h0000;
        else if (!up && position_count_reg == 16'h0000)
          pos_next = maximum_count_reg;
        wrap_evt = max_mode && ((up && position_count_reg == maximum_count_reg)
                   || (!up && position_count_reg == 16'h0000));
        period_evt = tmr_mode && (pos_next == maximum_count_reg);
      end
    end
    if (idx_mode && step)
      err_evt = (!up && pos_next == 16'hFFFF) || (up && {1'b0, pos_next} == max_p1);
    if (run && idx_mode && control_reg[CTL_INDEX_RESET_ENABLE] && idx_evt)
      pos_next = 16'h0000;
  end

  // Direction latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dir_reg <= 1'b0;
    else if (step)
      dir_reg <= up;
  end

  assign wr    = psel && penable && pwrite;
  assign rd_ok = (paddr == OFS_CONTROL) || (paddr == OFS_FILTER) || (paddr == OFS_POSITION_COUNT)
                 || (paddr == OFS_MAXIMUM_COUNT_LIMIT) || (paddr == OFS_STATUS);

  // Configuration registers; idle bit resets to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_reg       <= RST_CONTROL;
      filter_reg        <= RST_FILTER;
      maximum_count_reg <= RST_MAXIMUM_COUNT_LIMIT;
    end
    else if (wr)
    begin
      if (paddr == OFS_CONTROL)
        control_reg <= pwdata[15:0];
      if (paddr == OFS_FILTER)
        filter_reg <= pwdata[15:0];
      if (paddr == OFS_MAXIMUM_COUNT_LIMIT)
        maximum_count_reg <= pwdata[15:0];
    end
  end

  // counter only touched by steps, index resets or software, never by mode writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      position_count_reg <= RST_POSITION_COUNT;
    else if (wr && paddr == OFS_POSITION_COUNT)
      position_count_reg <= pwdata[15:0];
    else
      position_count_reg <= pos_next;
  end

  // error flag: set wins over software write
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_error_flag_reg <= 1'b0;
    else if (err_evt)
      count_error_flag_reg <= 1'b1;
    else if (wr && paddr == OFS_CONTROL)
      count_error_flag_reg <= pwdata[CTL_ERR];
  end

  // shared flag; index-mode wraps give none
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_reg <= 1'b0;
    else if ((err_evt && !filter_reg[FLT_COUNT_ERROR_IRQ_DISABLE]) || wrap_evt || period_evt
             || (run && idx_mode && idx_evt))
      irq_reg <= 1'b1;
    else if (wr && paddr == OFS_STATUS && pwdata[0])
      irq_reg <= 1'b0;
  end

  // APB slave, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= '0;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !rd_ok;
      prdata  <= '0;
      if (psel && !penable && !pwrite)
        case (paddr)
          OFS_CONTROL: prdata <= {16'h0000, count_error_flag_reg, control_reg[14:13],
                                  use_in.index, dir_reg, control_reg[10:0]};
          OFS_FILTER:  prdata <= {16'h0000, filter_reg};
          OFS_POSITION_COUNT:  prdata <= {16'h0000, position_count_reg};
          OFS_MAXIMUM_COUNT_LIMIT:  prdata <= {16'h0000, maximum_count_reg};
          OFS_STATUS:  prdata <= {31'h00000000, irq_reg};
          default:     prdata <= '0;
        endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      count_direction_out   <= 1'b0;
      count_direction_oe_n  <= 1'b1;
      module_interrupt_flag <= 1'b0;
    end
    else
    begin
      count_direction_out   <= dir_reg;
      count_direction_oe_n  <= !control_reg[CTL_DIROE];
      module_interrupt_flag <= irq_reg;
    end
  end

  // error flag follows a count error
  a_err_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
    err_evt |=> count_error_flag_reg) else $error("error flag not set");
  a_err_mode_only: assert property (@(posedge pclk) disable iff (!presetn)
    err_evt |-> idx_mode) else $error("error outside index mode");
  a_sleep_halts: assert property (@(posedge pclk) disable iff (!presetn)
    cpu_sleep |-> !step) else $error("step during sleep");
  // interrupt reaches pin two cycles later
  a_irq_pin: assert property (@(posedge pclk) disable iff (!presetn)
    (wrap_evt || period_evt) |=> ##1 module_interrupt_flag) else $error("irq lost");
  a_max_wrap: assert property (@(posedge pclk) disable iff (!presetn)
    (step && max_mode && up && position_count_reg == maximum_count_reg && !wr && !idx_evt)
    |=> position_count_reg == 16'h0000) else $error("no wrap");
  a_dir_oe: assert property (@(posedge pclk) disable iff (!presetn)
    control_reg[CTL_DIROE] |=> !count_direction_oe_n) else $error("dir pin off");
  a_index_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (run && idx_mode && control_reg[CTL_INDEX_RESET_ENABLE] && idx_evt && !wr)
    |=> position_count_reg == 16'h0000) else $error("index clear missing");
  a_step_one: assert property (@(posedge pclk) disable iff (!presetn)
    (step && x4 && !idx_evt && !wr && up && position_count_reg != 16'hFFFF && !max_mode)
    |=> position_count_reg == $past(position_count_reg) + 16'h0001) else $error("bad step");

  // filter output holds without three equal samples
  a_filter_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !(run && flt_tick && sync2_reg.phase_a == hist0_reg.phase_a && hist0_reg.phase_a == hist1_reg.phase_a)
    |=> $stable(flt_reg.phase_a)) else $error("filter changed early");

  // x2 modes ignore phase B edges
  a_x2_b_ignored: assert property (@(posedge pclk) disable iff (!presetn)
    (x2 && b_edge && !a_edge) |-> !step)
    else $error("x2 stepped on phase B");

  // timer period match raises the flag
  a_period_irq: assert property (@(posedge pclk) disable iff (!presetn)
    period_evt |=> irq_reg)
    else $error("period match lost");

  a_count_error_irq_disable_mask: assert property (@(posedge pclk) disable iff (!presetn)
    (err_evt && filter_reg[FLT_COUNT_ERROR_IRQ_DISABLE] && !idx_evt && !irq_reg) |=> !irq_reg)
    else $error("masked error interrupted");

  a_index_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (run && idx_mode && idx_evt) |=> irq_reg)
    else $error("index interrupt lost");

  // index modes give no wrap interrupt
  a_no_wrap_irq: assert property (@(posedge pclk) disable iff (!presetn)
    (step && idx_mode && !idx_evt && !err_evt && !irq_reg) |=> !irq_reg)
    else $error("wrap interrupt in index mode");

  // control writes leave the count alone
  a_mode_keeps_count: assert property (@(posedge pclk) disable iff (!presetn)
    (wr && paddr == OFS_CONTROL && !step && !idx_evt) |=> $stable(position_count_reg))
    else $error("mode write moved count");

  a_idle_halt: assert property (@(posedge pclk) disable iff (!presetn)
    (cpu_idle && control_reg[CTL_IDLE]) |-> !step)
    else $error("step during idle stop");

  a_filter_bypass: assert property (@(posedge pclk) disable iff (!presetn)
    (run && !filter_reg[FLT_OUTEN]) |=> prev_reg == $past(sync2_reg))
    else $error("filter used while off");

  a_irq_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (irq_reg && !(wr && paddr == OFS_STATUS && pwdata[0])) |=> irq_reg)
    else $error("flag dropped alone");

  // error flag holds until software writes
  a_err_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (count_error_flag_reg && !(wr && paddr == OFS_CONTROL)) |=> count_error_flag_reg)
    else $error("error flag dropped alone");
endmodule

/* File: hdl/qei_pkg.sv */
// Package for the quadrature encoder interface: register map, fields, resets.
// Assumes a 32-bit APB bus with word-aligned registers.
package qei_pkg;
  // Byte offsets of the registers (printed offsets are all even multiples)
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_FILTER  = 8'h04;
  localparam logic [7:0] OFS_POSITION_COUNT  = 8'h08;
  localparam logic [7:0] OFS_MAXIMUM_COUNT_LIMIT  = 8'h0C;
  localparam logic [7:0] OFS_STATUS  = 8'h10;
  // Control register fields
  localparam int CTL_ERR     = 15;
  localparam int CTL_IDLE    = 13;
  localparam int CTL_INDEX   = 12;
  localparam int CTL_DIR     = 11;
  localparam int CTL_MODE_LO = 8;
  localparam int CTL_DIROE   = 6;
  localparam int CTL_INDEX_RESET_ENABLE  = 2;
  localparam int CTL_DIRSRC  = 0;
  // Filter register fields
  localparam int FLT_COUNT_ERROR_IRQ_DISABLE    = 8;
  localparam int FLT_OUTEN   = 7;
  localparam int FLT_DIV_LO  = 4;
  // Reset values
  localparam logic [15:0] RST_CONTROL = 16'h0000;
  localparam logic [15:0] RST_FILTER  = 16'h0000;
  localparam logic [15:0] RST_POSITION_COUNT  = 16'h0000;
  localparam logic [15:0] RST_MAXIMUM_COUNT_LIMIT  = 16'hFFFF;
  // Number of encoder inputs filtered (bits of enc_t)
  localparam int FILTER_TAPS = 3;
  // Mode codes
  typedef enum logic [2:0] {
    MODE_OFF   = 3'h0,
    MODE_TIMER = 3'h1,
    MODE_X2IDX = 3'h4,
    MODE_X2MAX = 3'h5,
    MODE_X4IDX = 3'h6,
    MODE_X4MAX = 3'h7
  } mode_t;
  // Synchronised encoder inputs travel together
  typedef struct packed {
    logic index;
    logic phase_b;
    logic phase_a;
  } enc_t;
endpackage

/* File: bench/qei_encoder_model.sv */
// Behavioural incremental encoder: two phases in quadrature and an index.
// Assumes the bench calls its tasks; pins change just after pclk rises.
module qei_encoder_model (
  input  wire logic pclk,
  output logic      phase_a,
  output logic      phase_b,
  output logic      index
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] pos_reg = 2'h0;
  // Gray position to phase levels, state 0 has both low
  // A leads B forward
  assign phase_a = pos_reg[0] ^ pos_reg[1];
  assign phase_b = pos_reg[1];
  initial index = 1'b0;
  // Move n states, each held nine clocks
  task automatic step(input int n, input bit fwd);
    for (int i = 0; i < n; i++)
    begin
      @(posedge pclk);
      pos_reg <= fwd ? pos_reg + 2'h1 : pos_reg - 2'h1;
      repeat (8) @(posedge pclk);
    end
  endtask
  // Index pulse only while both phases are low
  // index at both low
  task automatic pulse_index();
    @(posedge pclk);
    index <= (pos_reg == 2'h0);
    repeat (8) @(posedge pclk);
    index <= 1'b0;
    repeat (8) @(posedge pclk);
  endtask
endmodule

/* File: bench/quadrature_encoder_interface_test.sv */
// Self-checking bench for the encoder interface, APB master and scenarios.
// Assumes the encoder model drives the phase pins; one 20 MHz clock.
module quadrature_encoder_interface_test;
  import qei_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk, presetn, psel, penable, pwrite, cpu_sleep, cpu_idle, last_err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        pready, pslverr, pa, pb, idx, dir_out, oe_n, irq;
  int          bad_count = 0;
  int          samples_checked = 0;
  int          cycles = 0;
  qei_core qei_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .phase_a_input(pa), .phase_b_input(pb), .index_input(idx),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .count_direction_out(dir_out),
    .count_direction_oe_n(oe_n), .module_interrupt_flag(irq));
  qei_encoder_model qei_encoder_model_inst (.pclk(pclk), .phase_a(pa), .phase_b(pb), .index(idx));
  // Clock generation
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Verdict and end of run
  task automatic conclude();
    if (bad_count == 0 && samples_checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      bad_count++;
      conclude();
    end
  end
  // Compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One APB transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    apb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    apb(1'b0, a, 32'h0, q);
    chk(q, exp);
  endtask
  task automatic clear_irq();
    wr(OFS_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk({31'h0, irq}, 32'h0);
  endtask
  task automatic t_reset();
    chk({30'h0, oe_n, irq}, 32'h2);
    rd(OFS_CONTROL, 32'h0);
    rd(OFS_FILTER, 32'h0);
    rd(OFS_POSITION_COUNT, 32'h0);
    rd(OFS_MAXIMUM_COUNT_LIMIT, 32'h0000FFFF);
    rd(8'h14, 32'h0);
    chk({31'h0, last_err}, 32'h1);
  endtask
  task automatic t_x4max();
    wr(OFS_MAXIMUM_COUNT_LIMIT, 32'h3);
    wr(OFS_CONTROL, 32'h0740);
    qei_encoder_model_inst.step(6, 1'b1);
    rd(OFS_POSITION_COUNT, 32'h2);
    chk({30'h0, dir_out, oe_n}, 32'h2);
    rd(OFS_CONTROL, 32'h0F40);
    chk({31'h0, irq}, 32'h1);
    clear_irq();
    qei_encoder_model_inst.step(3, 1'b0);
    rd(OFS_POSITION_COUNT, 32'h3);
    chk({31'h0, dir_out}, 32'h0);
    clear_irq();
  endtask
  task automatic t_x2();
    wr(OFS_CONTROL, 32'h0500);
    wr(OFS_MAXIMUM_COUNT_LIMIT, 32'h0000FFFF);
    wr(OFS_POSITION_COUNT, 32'h0);
    qei_encoder_model_inst.step(4, 1'b1);
    rd(OFS_POSITION_COUNT, 32'h2);
    clear_irq();
  endtask
  task automatic t_index();
    wr(OFS_CONTROL, 32'h0604);
    qei_encoder_model_inst.step(1, 1'b1);
    wr(OFS_POSITION_COUNT, 32'h5);
    qei_encoder_model_inst.pulse_index();
    rd(OFS_POSITION_COUNT, 32'h0);
    chk({31'h0, irq}, 32'h1);
    clear_irq();
    wr(OFS_CONTROL, 32'h0600);
    wr(OFS_POSITION_COUNT, 32'h5);
    qei_encoder_model_inst.pulse_index();
    rd(OFS_POSITION_COUNT, 32'h5);
    chk({31'h0, irq}, 32'h1);
    clear_irq();
  endtask
  task automatic t_error();
    wr(OFS_MAXIMUM_COUNT_LIMIT, 32'h3);
    wr(OFS_FILTER, 32'h0100);
    wr(OFS_POSITION_COUNT, 32'h0);
    qei_encoder_model_inst.step(4, 1'b1);
    rd(OFS_CONTROL, 32'h8E00);
    rd(OFS_POSITION_COUNT, 32'h4);
    chk({31'h0, irq}, 32'h0);
    wr(OFS_CONTROL, 32'h0600);
    rd(OFS_CONTROL, 32'h0E00);
    wr(OFS_FILTER, 32'h0);
    wr(OFS_POSITION_COUNT, 32'h0);
    qei_encoder_model_inst.step(1, 1'b0);
    rd(OFS_CONTROL, 32'h8600);
    chk({31'h0, irq}, 32'h1);
    clear_irq();
    wr(OFS_CONTROL, 32'h0600);
  endtask
  task automatic t_timer();
    wr(OFS_CONTROL, 32'h0900);
    rd(OFS_POSITION_COUNT, 32'h0000FFFF);
    wr(OFS_POSITION_COUNT, 32'h0);
    wr(OFS_MAXIMUM_COUNT_LIMIT, 32'h2);
    qei_encoder_model_inst.step(8, 1'b1);
    chk({31'h0, irq}, 32'h1);
    clear_irq();
    wr(OFS_CONTROL, 32'h0101);
    wr(OFS_POSITION_COUNT, 32'h5);
    qei_encoder_model_inst.step(4, 1'b1);
    rd(OFS_POSITION_COUNT, 32'h4);
  endtask
  task automatic t_power();
    wr(OFS_CONTROL, 32'h2700);
    wr(OFS_MAXIMUM_COUNT_LIMIT, 32'h0000FFFF);
    wr(OFS_POSITION_COUNT, 32'h0);
    cpu_idle <= 1'b1;
    qei_encoder_model_inst.step(4, 1'b1);
    cpu_idle <= 1'b0;
    rd(OFS_POSITION_COUNT, 32'h0);
    wr(OFS_CONTROL, 32'h0700);
    cpu_idle <= 1'b1;
    qei_encoder_model_inst.step(2, 1'b1);
    cpu_idle <= 1'b0;
    rd(OFS_POSITION_COUNT, 32'h2);
    cpu_sleep <= 1'b1;
    qei_encoder_model_inst.step(4, 1'b1);
    cpu_sleep <= 1'b0;
    rd(OFS_POSITION_COUNT, 32'h2);
    wr(OFS_FILTER, 32'h0090);
    qei_encoder_model_inst.step(4, 1'b1);
    rd(OFS_POSITION_COUNT, 32'h6);
    rd(OFS_FILTER, 32'h0090);
  endtask
  // Reset then the scenarios in order
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, cpu_sleep, cpu_idle, last_err} = 6'h0;
    paddr = 8'h0;
    pwdata = 32'h0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_x4max();
    t_x2();
    t_index();
    t_error();
    t_timer();
    t_power();
    conclude();
  end
endmodule
